// File: include/uosr_params.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 100 MHz clock and a plain strobe register port with word indices
//
// Operation
// - Session request signalling only at full speed, never low speed.
// - B-device needs bus power below session-valid and both lines low 2 ms.
// - Session-end flag set when power falls below session-end; 2 ms check in software.
// - On bus power removal, self-powered B-device clears both pull-up enables.
// - Discharge bit 0 set discharges bus power through resistor; clear means none.
// - Session request starts with plus-line pull-up held 5 to 10 ms.
// - Then the B-device pulses bus power through the pulse control bit.
// - A-device seeing attach or session-valid flag restores bus power supply.
// - B-device ignores power while pulsing; reconnects pull-up on session-valid.
// - A-device ends the session request by driving bus reset.
// - Host negotiation only at full speed and after A-device enables it.
// - Enabled B-device requests host role in suspend by clearing both pull-ups.
// - A-device seeing bus-reset flag hands over by setting plus-line pull-up.
// - A-device answering with resume keeps host role; B stays peripheral.
// - B-device seeing attach becomes host and drives bus reset first.
// - Host role returns: B pulls up, A drops pull-up after 3 ms idle.
// - Registers implement only the low byte; bits 15 to 8 read zero.
// - Descriptor page registers are 8-bit with bit 0 fixed at zero.
// - Status bit 7 reads 0 for Type A plug, 1 otherwise.
// - Status bit 5 reads 1 only if line state unchanged for 1 ms.
// - Status bits 3, 2, 0: session valid, below session end, bus valid.
// - OTG enable bit 2 gives software pull control; else host and module enables.
// - Control bits 7..4 enable each pull resistor; bits 3 and 1 stay zero.
// - Suspend enable gates the USB clock and holds transceiver low-power.
// - Activity-pending reads 1 when suspend is unwise; needs sleep guard set.
`ifndef UOSR_PARAMS_SVH
`define UOSR_PARAMS_SVH

// Register word indices
`define UOSR_IDX_STAT      4'h0
`define UOSR_IDX_OTGCON    4'h1
`define UOSR_IDX_PWRC      4'h2
`define UOSR_IDX_CON       4'h3
`define UOSR_IDX_IRQ       4'h4
`define UOSR_IDX_CNFG2     4'h5
`define UOSR_IDX_BDTP1     4'h6
`define UOSR_IDX_BDTP2     4'h7
`define UOSR_IDX_BDTP3     4'h8

// Status fields
`define UOSR_ST_PLUG       7
`define UOSR_ST_LSTABLE    5
`define UOSR_ST_SESSVLD    3
`define UOSR_ST_SESSEND    2
`define UOSR_ST_BUSVLD     0

// Pull control fields
`define UOSR_OC_DPUP       7
`define UOSR_OC_DMUP       6
`define UOSR_OC_DPDN       5
`define UOSR_OC_DMDN       4
`define UOSR_OC_OTG_FEATURES_ENABLE      2
`define UOSR_OC_DISCH      0
`define UOSR_OC_WMASK      8'hf5

// Power control fields
`define UOSR_PW_ACTPND     7
`define UOSR_PW_GUARD      4
`define UOSR_PW_SUSP       1
`define UOSR_PW_PWR        0
`define UOSR_PW_WMASK      8'h13

// Module control fields
`define UOSR_CN_RESUME     2
`define UOSR_CN_BUSRST     4
`define UOSR_CN_HOST_ROLE_ENABLE     3
`define UOSR_CN_MODEN      0
`define UOSR_CN_LSPD       7
`define UOSR_CN_WMASK      8'h9d

// Flag fields
`define UOSR_IR_ATTACH     6
`define UOSR_IR_SESSVLD    3
`define UOSR_IR_SESSEND    2
`define UOSR_IR_BUSRST     0

// Config 2 fields
`define UOSR_C2_PULSE      4
`define UOSR_C2_HNPEN      0
`define UOSR_C2_WMASK      8'h11

// Reset values
`define UOSR_RST_BYTE      8'h00

// Timing
`define UOSR_CLK_MHZ       100
`define UOSR_STABLE_US     1000
`define UOSR_IDLE_US       3000
`define UOSR_STABLE_CYC    (`UOSR_STABLE_US * `UOSR_CLK_MHZ)
`define UOSR_IDLE_CYC      (`UOSR_IDLE_US * `UOSR_CLK_MHZ)

`endif

// File: include/uosr_pkg.sv
// Types shared by the session and role control block
// Assumes the params header supplies the numbers
package uosr_pkg;

  // Analog comparator and line inputs
  typedef struct packed {
    logic plug_type_state;
    logic sess_valid;
    logic sess_end;
    logic bus_valid;
    logic line_se0;
    logic line_j;
  } uosr_line_t;

  // Pin-facing controls
  typedef struct packed {
    logic plus_line_pullup_en;
    logic minus_line_pullup_en;
    logic plus_line_pulldown_en;
    logic minus_line_pulldown_en;
    logic bus_power_discharge_en;
    logic bus_power_pulse_ctl;
  } uosr_pins_t;

  // Role of the port after negotiation
  typedef enum logic [1:0] {
    UOSR_PERIPH  = 2'b00,
    UOSR_REQ     = 2'b01,
    UOSR_HOST    = 2'b11,
    UOSR_RETURN  = 2'b10
  } uosr_role_t;

endpackage

// File: design/uosr_top.sv
// Session and role control for an OTG dual-role port
// Assumes a strobe register port on clk_i and async line inputs from pins
`timescale 1ns/1ps
`include "uosr_params.svh"

module uosr_top #(
  parameter int STABLE_CYC = `UOSR_STABLE_CYC,
  parameter int IDLE_CYC   = `UOSR_IDLE_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic [3:0]        addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  input  wire uosr_pkg::uosr_line_t line_i,
  input  wire logic              activity_i,
  output uosr_pkg::uosr_pins_t   pins_o,
  output logic                   supply_en_o,
  output logic                   bus_reset_o,
  output logic                   resume_o,
  output logic                   usb_clk_gate_o,
  output logic                   xcvr_lowpower_o,
  output uosr_pkg::uosr_role_t   role_o
);

  // Counts below two leave the window and idle compares without a usable range
  if (STABLE_CYC < 2 || IDLE_CYC < 2)
  begin : g_bad_counts
    $error("uosr_top: timing counts too small");
  end

  //////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Async assert, two-stage release
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  uosr_pkg::uosr_line_t line_s1_reg;
  uosr_pkg::uosr_line_t line_reg;
  logic                 act_s1_reg;
  logic                 act_reg;

  // Pins are asynchronous; only line_reg and act_reg are read
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_s1_reg <= '0;
      line_reg    <= '0;
      act_s1_reg  <= 1'b0;
      act_reg     <= 1'b0;
    end
    else
    begin
      line_s1_reg <= line_i;
      line_reg    <= line_s1_reg;
      act_s1_reg  <= activity_i;
      act_reg     <= act_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software registers

  logic [7:0] otgcon_reg;
  logic [7:0] pwrc_reg;
  logic [7:0] con_reg;
  logic [7:0] cnfg2_reg;
  logic [7:0] bdtp_reg [3];
  logic       wr_otg;
  logic       wr_pwr;
  logic       wr_con;
  logic       wr_c2;

  assign wr_otg = wr_i && addr_i == `UOSR_IDX_OTGCON;
  assign wr_pwr = wr_i && addr_i == `UOSR_IDX_PWRC;
  assign wr_con = wr_i && addr_i == `UOSR_IDX_CON;
  assign wr_c2  = wr_i && addr_i == `UOSR_IDX_CNFG2;

  // Pull control; reserved bits 3 and 1 held at zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      otgcon_reg <= `UOSR_RST_BYTE;
    else if (wr_otg)
      otgcon_reg <= wdata_i[7:0] & `UOSR_OC_WMASK;
  end

  logic susp_clr;

  // Power control; suspend is hardware-cleared on resume activity
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pwrc_reg <= `UOSR_RST_BYTE;
    else if (wr_pwr)
      pwrc_reg <= wdata_i[7:0] & `UOSR_PW_WMASK;
    else if (susp_clr)
      pwrc_reg[`UOSR_PW_SUSP] <= 1'b0;
  end

  // Module control: host/module enables, reset and resume drive
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      con_reg <= `UOSR_RST_BYTE;
    else if (wr_con)
      con_reg <= wdata_i[7:0] & `UOSR_CN_WMASK;
  end

  // Config 2: bus power pulse and negotiation enable
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cnfg2_reg <= `UOSR_RST_BYTE;
    else if (wr_c2)
      cnfg2_reg <= wdata_i[7:0] & `UOSR_C2_WMASK;
  end

  // Descriptor pages, bit 0 forced to zero for alignment
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
        bdtp_reg[i] <= `UOSR_RST_BYTE;
    end
    else if (wr_i && addr_i >= `UOSR_IDX_BDTP1 && addr_i <= `UOSR_IDX_BDTP3)
      bdtp_reg[2'(addr_i - `UOSR_IDX_BDTP1)] <= {wdata_i[7:1], 1'b0};
  end

  //////////////////////////////////////////////////////////////////////
  // Line stability timer

  logic [1:0]  line_stable_flag_prev_reg;
  logic [31:0] stab_cnt_reg;
  logic        stable_reg;
  logic [1:0]  line_stable_flag;

  assign line_stable_flag = {line_reg.line_se0, line_reg.line_j};

  // Any change restarts the 1 ms window
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_stable_flag_prev_reg <= 2'b00;
      stab_cnt_reg    <= '0;
      stable_reg      <= 1'b0;
    end
    else
    begin
      line_stable_flag_prev_reg <= line_stable_flag;
      if (line_stable_flag != line_stable_flag_prev_reg)
      begin
        stab_cnt_reg <= '0;
        stable_reg   <= 1'b0;
      end
      else if (stab_cnt_reg >= 32'(STABLE_CYC - 1))
        stable_reg <= 1'b1;
      else
        stab_cnt_reg <= stab_cnt_reg + 32'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky event flags, write one to clear, set wins

  logic [7:0] irq_reg;
  logic       sv_prev_reg;
  logic       se_prev_reg;
  logic       se0_prev_reg;
  logic [7:0] irq_set;
  logic [2:0] warm_reg;

  // History regs start at zero, not at the pin level; mask edges until they hold real data
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      warm_reg <= 3'b000;
    else
      warm_reg <= {warm_reg[1:0], 1'b1};
  end

  always_comb
  begin
    irq_set                    = 8'h00;
    irq_set[`UOSR_IR_SESSVLD] = line_reg.sess_valid && !sv_prev_reg && warm_reg[2];
    irq_set[`UOSR_IR_SESSEND] = line_reg.sess_end && !se_prev_reg && warm_reg[2];
    irq_set[`UOSR_IR_ATTACH]  = se0_prev_reg && !line_reg.line_se0 && stable_reg && warm_reg[2];
    irq_set[`UOSR_IR_BUSRST]  = line_reg.line_se0 && !se0_prev_reg && warm_reg[2];
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_reg      <= `UOSR_RST_BYTE;
      sv_prev_reg  <= 1'b0;
      se_prev_reg  <= 1'b0;
      se0_prev_reg <= 1'b0;
    end
    else
    begin
      sv_prev_reg  <= line_reg.sess_valid;
      se_prev_reg  <= line_reg.sess_end;
      se0_prev_reg <= line_reg.line_se0;
      irq_reg      <= (irq_reg & ~((wr_i && addr_i == `UOSR_IDX_IRQ) ? wdata_i[7:0] : 8'h00)) | irq_set;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Role tracking for negotiation and host role return

  uosr_pkg::uosr_role_t role_reg;
  logic [31:0]          idle_cnt_reg;
  logic                 full_speed;
  logic                 hnp_ok;
  logic                 a_side;

  assign full_speed = !con_reg[`UOSR_CN_LSPD];
  assign a_side     = !line_reg.plug_type_state;
  assign hnp_ok     = full_speed && cnfg2_reg[`UOSR_C2_HNPEN];

  // Host role follows disconnect, attach and idle events
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      role_reg     <= uosr_pkg::UOSR_PERIPH;
      idle_cnt_reg <= '0;
    end
    else
    begin
      unique case (role_reg)
        uosr_pkg::UOSR_PERIPH:
          if (hnp_ok && !a_side && stable_reg && !pins_o.plus_line_pullup_en && !pins_o.minus_line_pullup_en)
            role_reg <= uosr_pkg::UOSR_REQ;
        uosr_pkg::UOSR_REQ:
          if (con_reg[`UOSR_CN_RESUME])
            role_reg <= uosr_pkg::UOSR_PERIPH;
          else if (irq_set[`UOSR_IR_ATTACH])
            role_reg <= uosr_pkg::UOSR_HOST;
        uosr_pkg::UOSR_HOST:
          if (otgcon_reg[`UOSR_OC_DPUP])
          begin
            role_reg     <= uosr_pkg::UOSR_RETURN;
            idle_cnt_reg <= '0;
          end
        uosr_pkg::UOSR_RETURN:
          if (!stable_reg)
            idle_cnt_reg <= '0;
          else if (idle_cnt_reg >= 32'(IDLE_CYC - 1))
            role_reg <= uosr_pkg::UOSR_PERIPH;
          else
            idle_cnt_reg <= idle_cnt_reg + 32'd1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin controls

  logic pulse_ok;

  // Session request only at full speed while on the B side
  assign pulse_ok = full_speed && !a_side;

  // Pull resistors: software under OTG enable, else from host/module enables
  always_comb
  begin
    if (otgcon_reg[`UOSR_OC_OTG_FEATURES_ENABLE])
    begin
      pins_o.plus_line_pullup_en    = otgcon_reg[`UOSR_OC_DPUP];
      pins_o.minus_line_pullup_en   = otgcon_reg[`UOSR_OC_DMUP];
      pins_o.plus_line_pulldown_en  = otgcon_reg[`UOSR_OC_DPDN];
      pins_o.minus_line_pulldown_en = otgcon_reg[`UOSR_OC_DMDN];
    end
    else
    begin
      pins_o.plus_line_pullup_en    = con_reg[`UOSR_CN_MODEN] && !con_reg[`UOSR_CN_HOST_ROLE_ENABLE];
      pins_o.minus_line_pullup_en   = 1'b0;
      pins_o.plus_line_pulldown_en  = con_reg[`UOSR_CN_HOST_ROLE_ENABLE];
      pins_o.minus_line_pulldown_en = con_reg[`UOSR_CN_HOST_ROLE_ENABLE];
    end
    pins_o.bus_power_discharge_en = otgcon_reg[`UOSR_OC_DISCH];
    pins_o.bus_power_pulse_ctl    = cnfg2_reg[`UOSR_C2_PULSE] && pulse_ok;
  end

  // Supply follows software enable on the A side only; bus reset and resume from control
  assign supply_en_o = pwrc_reg[`UOSR_PW_PWR] && a_side;
  assign bus_reset_o = con_reg[`UOSR_CN_BUSRST];
  assign resume_o    = con_reg[`UOSR_CN_RESUME];
  assign role_o      = role_reg;

  // Suspend gating; activity while the line is not J clears suspend, guard not used
  assign usb_clk_gate_o  = pwrc_reg[`UOSR_PW_SUSP];
  assign xcvr_lowpower_o = pwrc_reg[`UOSR_PW_SUSP];
  assign susp_clr        = pwrc_reg[`UOSR_PW_SUSP] && act_reg && !line_reg.line_j;

  //////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after strobe

  logic [7:0] rd_byte;
  logic [7:0] stat_byte;

  always_comb
  begin
    stat_byte                    = 8'h00;
    stat_byte[`UOSR_ST_PLUG]    = line_reg.plug_type_state;
    stat_byte[`UOSR_ST_LSTABLE] = stable_reg;
    stat_byte[`UOSR_ST_SESSVLD] = line_reg.sess_valid;
    stat_byte[`UOSR_ST_SESSEND] = line_reg.sess_end;
    stat_byte[`UOSR_ST_BUSVLD]  = line_reg.bus_valid;
    unique case (addr_i)
      `UOSR_IDX_STAT:   rd_byte = stat_byte;
      `UOSR_IDX_OTGCON: rd_byte = otgcon_reg;
      `UOSR_IDX_PWRC:   rd_byte = pwrc_reg | {pwrc_reg[`UOSR_PW_GUARD] && act_reg, 7'h00};
      `UOSR_IDX_CON:    rd_byte = con_reg;
      `UOSR_IDX_IRQ:    rd_byte = irq_reg;
      `UOSR_IDX_CNFG2:  rd_byte = cnfg2_reg;
      `UOSR_IDX_BDTP1:  rd_byte = bdtp_reg[0];
      `UOSR_IDX_BDTP2:  rd_byte = bdtp_reg[1];
      `UOSR_IDX_BDTP3:  rd_byte = bdtp_reg[2];
      default:          rd_byte = 8'h00;
    endcase
  end

  // Upper byte always zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 16'h0000;
    else if (rd_i)
      rdata_o <= {8'h00, rd_byte};
    else
      rdata_o <= 16'h0000;
  end

endmodule

// File: tb/uosr_props.sv
// Checker for the session and role control block
// Assumes it is bound to uosr_top and sees only that module's ports
`timescale 1ns/1ps
module uosr_props #(
  parameter int STABLE_CYC = 20,
  parameter int IDLE_CYC   = 40
) (
  input wire logic                 clk_i,
  input wire logic                 nrst_i,
  input wire logic [3:0]           addr_i,
  input wire logic [15:0]          wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [15:0]          rdata_o,
  input wire uosr_pkg::uosr_line_t line_i,
  input wire logic                 activity_i,
  input wire uosr_pkg::uosr_pins_t pins_o,
  input wire logic                 supply_en_o,
  input wire logic                 bus_reset_o,
  input wire logic                 resume_o,
  input wire logic                 usb_clk_gate_o,
  input wire logic                 xcvr_lowpower_o,
  input wire uosr_pkg::uosr_role_t role_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////
  // Register port
  a_upper_byte_zero: assert property (rdata_o[15:8] == 8'h00)
    else $error("upper read byte not zero");
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");

  ////////////////////////////////////////////////////////////////
  // Pin controls follow the pull, power and module control words
  a_discharge_follows: assert property (wr_i && addr_i == 4'h1 |=>
    pins_o.bus_power_discharge_en == $past(wdata_i[0])) else $error("discharge pin wrong");
  a_pull_sw_ctl: assert property (wr_i && addr_i == 4'h1 && wdata_i[2] |=>
    pins_o.plus_line_pullup_en == $past(wdata_i[7]) && pins_o.minus_line_pullup_en == $past(wdata_i[6])
    && pins_o.plus_line_pulldown_en == $past(wdata_i[5])) else $error("pull pins wrong");
  a_pulse_lowspeed: assert property (wr_i && addr_i == 4'h3 && wdata_i[7] |=>
    !pins_o.bus_power_pulse_ctl) else $error("power pulse at low speed");
  a_supply_off: assert property (wr_i && addr_i == 4'h2 && !wdata_i[0] |=> !supply_en_o)
    else $error("supply enable without power bit");
  a_ctl_drive: assert property (wr_i && addr_i == 4'h3 |=>
    bus_reset_o == $past(wdata_i[4]) && resume_o == $past(wdata_i[2])) else $error("reset or resume wrong");

  ////////////////////////////////////////////////////////////////
  // Suspend gating
  a_gate_pair: assert property (usb_clk_gate_o == xcvr_lowpower_o)
    else $error("gate and low power differ");
  a_suspend_set: assert property ((!activity_i)[*3] ##0 (wr_i && addr_i == 4'h2 && wdata_i[1])
    |=> usb_clk_gate_o) else $error("suspend not applied");

  ////////////////////////////////////////////////////////////////
  // Role changes
  a_host_entry: assert property ($past(role_o) != uosr_pkg::UOSR_HOST && role_o == uosr_pkg::UOSR_HOST
    |-> $past(role_o) == uosr_pkg::UOSR_REQ) else $error("host role without request");
  a_req_entry: assert property ($past(role_o) == uosr_pkg::UOSR_PERIPH && role_o == uosr_pkg::UOSR_REQ
    |-> !$past(pins_o.plus_line_pullup_en) && !$past(pins_o.minus_line_pullup_en))
    else $error("request with pull-up on");

  c_host: cover property (role_o == uosr_pkg::UOSR_HOST);
  c_return: cover property (role_o == uosr_pkg::UOSR_RETURN);
  c_pulse: cover property (pins_o.bus_power_pulse_ctl);
endmodule

bind uosr_top uosr_props #(.STABLE_CYC(STABLE_CYC), .IDLE_CYC(IDLE_CYC)) uosr_props_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .line_i(line_i), .activity_i(activity_i), .pins_o(pins_o),
  .supply_en_o(supply_en_o), .bus_reset_o(bus_reset_o), .resume_o(resume_o),
  .usb_clk_gate_o(usb_clk_gate_o), .xcvr_lowpower_o(xcvr_lowpower_o), .role_o(role_o));

// File: tb/uosr_far_end.sv
// Model of the far dual-role device: bus power and data line state
// Assumes the bench steers its supply, plug and pull-up by plain inputs
`timescale 1ns/1ps
module uosr_far_end (
  input  wire logic                 clk_i,
  input  wire uosr_pkg::uosr_pins_t pins_i,
  input  wire logic                 supply_en_i,
  input  wire logic                 plug_a_i,
  input  wire logic                 supply_i,
  input  wire logic                 far_pullup_i,
  output uosr_pkg::uosr_line_t      line_o
);
  logic [2:0] pulse_cnt = 3'h0;
  logic       restored  = 1'b0;
  logic       power;
  logic       pulled;

  ////////////////////////////////////////////////////////////////
  // Power comes back a few cycles after a pulse, so it is never instant
  always_ff @(posedge clk_i)
  begin
    pulse_cnt <= pins_i.bus_power_pulse_ctl ? pulse_cnt + 3'h1 : 3'h0;
    if (supply_i)
      restored <= 1'b0;
    else if (pulse_cnt == 3'h4)
      restored <= 1'b1;
  end

  // Line is J whenever either end pulls up, else both lines low
  assign power  = supply_i | restored | supply_en_i;
  assign pulled = pins_i.plus_line_pullup_en | pins_i.minus_line_pullup_en | far_pullup_i;
  assign line_o = '{plug_type_state: !plug_a_i, sess_valid: power, sess_end: !power,
                    bus_valid: power, line_se0: !pulled, line_j: pulled};
endmodule

// File: tb/tb_uosr_top.sv
// Self-checking bench for the session and role control block
// Assumes the far-end model drives the line inputs
`timescale 1ns/1ps
module tb_uosr_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic activity = 1'b0;
  logic plug_a = 1'b0;
  logic supply = 1'b0;
  logic far_pull = 1'b0;
  logic [15:0] rdata_o;
  uosr_pkg::uosr_line_t line;
  uosr_pkg::uosr_pins_t pins_o;
  uosr_pkg::uosr_role_t role_o;
  logic supply_en_o, bus_reset_o, resume_o, usb_clk_gate_o, xcvr_lowpower_o;
  int errors = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////
  // Short counts keep the run brief
  uosr_top #(.STABLE_CYC(20), .IDLE_CYC(40)) uosr_top_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o), .line_i(line),
    .activity_i(activity), .pins_o(pins_o), .supply_en_o(supply_en_o), .bus_reset_o(bus_reset_o),
    .resume_o(resume_o), .usb_clk_gate_o(usb_clk_gate_o), .xcvr_lowpower_o(xcvr_lowpower_o), .role_o(role_o));
  uosr_far_end uosr_far_end_i (.clk_i(clk_i), .pins_i(pins_o), .supply_en_i(supply_en_o),
    .plug_a_i(plug_a), .supply_i(supply), .far_pullup_i(far_pull), .line_o(line));

  // Clock at 100 MHz
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////
  // Bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_role(input uosr_pkg::uosr_role_t got, input uosr_pkg::uosr_role_t exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: role %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s done, errors %0d", name, errors);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    rchk(4'h1, 16'h0000);
    rchk(4'h3, 16'h0000);
    wr(4'h1, 16'hffff);
    rchk(4'h1, 16'h00f5);
    chk({10'h000, pins_o}, 16'h003e);
    wr(4'h6, 16'hffff);
    rchk(4'h6, 16'h00fe);
    wr(4'h9, 16'h00ff);
    rchk(4'h9, 16'h0000);
    wr(4'h1, 16'h0001);
    chk({10'h000, pins_o}, 16'h0002);
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0001);
    chk({10'h000, pins_o}, 16'h0020);
    wr(4'h3, 16'h0008);
    chk({10'h000, pins_o}, 16'h000c);
    wr(4'h3, 16'h0000);
    done("regs");
  endtask
  task automatic t_status;
    cyc(30);
    rchk(4'h0, 16'h00a4);
    supply = 1'b1;
    cyc(5);
    rchk(4'h0, 16'h00a9);
    far_pull = 1'b1;
    cyc(3);
    rchk(4'h0, 16'h0089);
    cyc(25);
    rchk(4'h0, 16'h00a9);
    plug_a = 1'b1;
    cyc(4);
    rchk(4'h0, 16'h0029);
    wr(4'h2, 16'h0001);
    chk({15'h0000, supply_en_o}, 16'h0001);
    wr(4'h2, 16'h0000);
    plug_a = 1'b0;
    done("status");
  endtask
  task automatic t_srp;
    far_pull = 1'b0;
    cyc(5);
    wr(4'h4, 16'h00ff);
    supply = 1'b0;
    cyc(5);
    rchk(4'h4, 16'h0004);
    wr(4'h1, 16'h0084);
    chk({10'h000, pins_o}, 16'h0020);
    wr(4'h1, 16'h0004);
    cyc(5);
    rchk(4'h4, 16'h0005);
    wr(4'h4, 16'h00ff);
    wr(4'h5, 16'h0010);
    chk({15'h0000, pins_o.bus_power_pulse_ctl}, 16'h0001);
    cyc(10);
    rchk(4'h4, 16'h0008);
    wr(4'h3, 16'h0080);
    chk({15'h0000, pins_o.bus_power_pulse_ctl}, 16'h0000);
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'h0000);
    supply = 1'b1;
    done("srp");
  endtask
  task automatic t_hnp;
    cyc(30);
    chk_role(role_o, uosr_pkg::UOSR_PERIPH);
    wr(4'h5, 16'h0001);
    cyc(4);
    chk_role(role_o, uosr_pkg::UOSR_REQ);
    wr(4'h3, 16'h0004);
    chk({15'h0000, resume_o}, 16'h0001);
    cyc(1);
    chk_role(role_o, uosr_pkg::UOSR_PERIPH);
    wr(4'h3, 16'h0000);
    cyc(2);
    chk_role(role_o, uosr_pkg::UOSR_REQ);
    far_pull = 1'b1;
    cyc(6);
    chk_role(role_o, uosr_pkg::UOSR_HOST);
    wr(4'h3, 16'h0010);
    chk({15'h0000, bus_reset_o}, 16'h0001);
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'h0084);
    cyc(2);
    chk_role(role_o, uosr_pkg::UOSR_RETURN);
    far_pull = 1'b0;
    cyc(10);
    chk_role(role_o, uosr_pkg::UOSR_RETURN);
    cyc(50);
    chk_role(role_o, uosr_pkg::UOSR_PERIPH);
    wr(4'h5, 16'h0000);
    done("hnp");
  endtask
  task automatic t_power;
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0011);
    activity <= 1'b1;
    cyc(4);
    rchk(4'h2, 16'h0091);
    activity <= 1'b0;
    cyc(4);
    wr(4'h2, 16'h0013);
    chk({14'h0000, usb_clk_gate_o, xcvr_lowpower_o}, 16'h0003);
    wr(4'h2, 16'h0011);
    chk({14'h0000, usb_clk_gate_o, xcvr_lowpower_o}, 16'h0000);
    wr(4'h2, 16'h0013);
    activity <= 1'b1;
    cyc(4);
    chk({14'h0000, usb_clk_gate_o, xcvr_lowpower_o}, 16'h0000);
    activity <= 1'b0;
    wr(4'h2, 16'h0000);
    done("power");
  endtask

  ////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic final_report;
    $display("checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(3);
    t_regs();
    t_status();
    t_srp();
    t_hnp();
    t_power();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end
endmodule
